//--- pbm_map.svh
`ifndef PBM_MAP_SVH
`define PBM_MAP_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define PBM_ADDR_CTRL      5'h00
`define PBM_ADDR_STAT      5'h01
`define PBM_ADDR_IDH       5'h02
`define PBM_ADDR_IDL       5'h03

// ------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------
`define PBM_C_RST          15
`define PBM_C_LOOP         14
`define PBM_C_SPD_LO       13
`define PBM_C_ANEN         12
`define PBM_C_PDN          11
`define PBM_C_ISO          10
`define PBM_C_ANRS         9
`define PBM_C_DUP          8
`define PBM_C_COLT         7
`define PBM_C_SPD_HI       6

// Writable control bits; 5:0 read zero
`define PBM_CTRL_WMASK     16'hFF_C0
`define PBM_CTRL_RST_VAL   16'h10_40

// ------------------------------------------------------------
// Status field positions and fixed bits
// ------------------------------------------------------------
`define PBM_S_ANDONE       5
`define PBM_S_RFLT         4
`define PBM_S_LINK         2
`define PBM_S_JAB          1
`define PBM_STAT_FIXED     16'h79_C9

// ------------------------------------------------------------
// Identity, values arbitrary
// ------------------------------------------------------------
`define PBM_OUI_HI         16'h12_34
`define PBM_OUI_LO         6'h2A
`define PBM_MODEL          6'h15
`define PBM_REV            4'h3

`endif

//--- pbm_pkg.sv
package pbm_pkg;
   typedef logic [15:0] pbm_word_t;
   typedef logic [4:0]  pbm_addr_t;
   typedef enum logic [1:0] {
      PBM_SPD_10   = 2'h0,
      PBM_SPD_100  = 2'h1,
      PBM_SPD_1000 = 2'h2,
      PBM_SPD_RSV  = 2'h3
   } pbm_speed_e;
endpackage

//--- pbm_latch.sv
`include "pbm_map.svh"

// Latching status bit: holds captured event until a read consumes it
module pbm_latch (
   input  wire logic i_clk,      // System clock
   input  wire logic i_sys_rst,  // Sync reset, high
   input  wire logic i_live,     // Live condition
   input  wire logic i_low,      // 1: latch low, 0: latch high
   input  wire logic i_rd,       // Status register read pulse
   output logic      o_val       // Reported value
);
   import pbm_pkg::*;

   typedef struct packed {
      logic held;
   } pbm_lat_s;

   pbm_lat_s st_r;
   pbm_lat_s st_nxt;

   // Captured event shows in place of live until read
   assign o_val = st_r.held ? ~i_low : i_live;

   always_comb begin
      st_nxt = st_r;
      // Event seen in the read cycle survives the read
      if (i_rd)
         st_nxt.held = 1'b0;
      if (i_live == ~i_low)
         st_nxt.held = 1'b1;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
endmodule

//--- pbm_regs.sv
`include "pbm_map.svh"

module pbm_regs (
   input  wire logic            i_clk,        // System clock 20 MHz
   input  wire logic            i_sys_rst,    // Sync reset, high
   input  wire logic            i_wr,         // Register write strobe
   input  wire logic            i_rd,         // Register read strobe
   input  wire pbm_pkg::pbm_addr_t i_addr,    // Register address
   input  wire pbm_pkg::pbm_word_t i_wdata,   // Write data
   output pbm_pkg::pbm_word_t   o_rdata,      // Read data, registered
   input  wire logic            i_link_up,    // Media link live (async)
   input  wire logic            i_rem_fault,  // Remote fault live (async)
   input  wire logic            i_jabber,     // Jabber live (async)
   input  wire logic            i_an_done,    // Autoneg complete (async)
   input  wire logic [7:0]      i_mac_txd,    // MAC-side data in
   input  wire logic            i_mac_txen,   // MAC-side enable in
   output logic [7:0]           o_mac_txd,    // Data to media side
   output logic                 o_mac_txen,   // Enable to media side
   input  wire logic [7:0]      i_med_rxd,    // Data from media side
   input  wire logic            i_med_rxdv,   // Valid from media side
   output logic [7:0]           o_mac_rxd,    // MAC-side data out
   output logic                 o_mac_rxdv,   // MAC-side valid out
   output logic                 o_mac_oe,     // MAC-side output enable
   output logic                 o_loopback,   // Loopback enabled
   output pbm_pkg::pbm_speed_e  o_speed,      // Forced speed code
   output logic                 o_full_dup,   // Full duplex selected
   output logic                 o_an_en,      // Autoneg enabled
   output logic                 o_an_restart, // Autoneg restart pulse
   output logic                 o_power_down, // Power-down
   output logic                 o_col_test,   // Collision test enabled
   output logic                 o_soft_rst    // Soft reset pulse to port
);
   import pbm_pkg::*;

   typedef struct packed {
      pbm_word_t  ctrl;
      pbm_word_t  rdata;
      logic       an_rs;
      logic       srst;
      logic [3:0] sync1;
      logic [3:0] sync2;
   } pbm_st_s;

   pbm_st_s st_r;
   pbm_st_s st_nxt;

   // ---------------------------------------------------------
   // Status bits: link, remote fault and jabber latched; autoneg done unlatched
   // ---------------------------------------------------------
   logic stat_rd;
   logic link_v;
   logic rflt_v;
   logic jab_v;
   logic an_done_v;

   // Synchroniser stage two only feeds the logic below
   assign stat_rd = i_rd && (i_addr == `PBM_ADDR_STAT);

   pbm_latch u_link (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_live    (st_r.sync2[0]),
      .i_low     (1'b1),
      .i_rd      (stat_rd),
      .o_val     (link_v)
   );

   pbm_latch u_rflt (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_live    (st_r.sync2[1]),
      .i_low     (1'b0),
      .i_rd      (stat_rd),
      .o_val     (rflt_v)
   );

   pbm_latch u_jab (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_live    (st_r.sync2[2]),
      .i_low     (1'b0),
      .i_rd      (stat_rd),
      .o_val     (jab_v)
   );

   // Completion only counts while negotiation is enabled and not restarting
   assign an_done_v = st_r.sync2[3] && st_r.ctrl[`PBM_C_ANEN]
                      && !st_r.an_rs;

   // ---------------------------------------------------------
   // Read decode
   // ---------------------------------------------------------
   function automatic pbm_word_t stat_word(input logic lk, input logic rf,
                                           input logic jb, input logic ad);
      pbm_word_t w;
      w = `PBM_STAT_FIXED;
      w[`PBM_S_ANDONE] = ad;
      w[`PBM_S_RFLT]   = rf;
      w[`PBM_S_LINK]   = lk;
      w[`PBM_S_JAB]    = jb;
      return w;
   endfunction

   function automatic pbm_word_t rd_mux(input pbm_addr_t a, input pbm_word_t c,
                                        input pbm_word_t s);
      pbm_word_t w;
      w = 16'h00_00;
      unique case (a)
         `PBM_ADDR_CTRL: w = c & `PBM_CTRL_WMASK;
         `PBM_ADDR_STAT: w = s;
         `PBM_ADDR_IDH:  w = `PBM_OUI_HI;
         `PBM_ADDR_IDL:  w = {`PBM_OUI_LO, `PBM_MODEL, `PBM_REV};
         default:        w = 16'h00_00;
      endcase
      return w;
   endfunction

   // ---------------------------------------------------------
   // Next state
   // ---------------------------------------------------------
   always_comb begin
      pbm_word_t wv;
      wv = i_wdata & `PBM_CTRL_WMASK;
      st_nxt = st_r;
      st_nxt.sync1 = {i_an_done, i_jabber, i_rem_fault, i_link_up};
      st_nxt.sync2 = st_r.sync1;
      // Self-clearing bits read back one for one cycle only
      st_nxt.ctrl[`PBM_C_RST]  = 1'b0;
      st_nxt.ctrl[`PBM_C_ANRS] = 1'b0;
      st_nxt.an_rs = 1'b0;
      st_nxt.srst  = 1'b0;
      if (st_r.srst) begin
         // Latched status flags are sticky and survive a soft reset
         st_nxt.ctrl = `PBM_CTRL_RST_VAL;
      end else if (i_wr && i_addr == `PBM_ADDR_CTRL) begin
         st_nxt.ctrl = wv;
         st_nxt.srst = wv[`PBM_C_RST];
         st_nxt.an_rs = wv[`PBM_C_ANRS];
      end
      st_nxt.rdata = i_rd ? rd_mux(i_addr, st_r.ctrl,
                                   stat_word(link_v, rflt_v, jab_v, an_done_v))
                          : st_r.rdata;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st_r       <= '0;
         st_r.ctrl  <= `PBM_CTRL_RST_VAL;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------
   // Port steering
   // ---------------------------------------------------------
   logic iso;
   assign iso = st_r.ctrl[`PBM_C_ISO];

   assign o_rdata      = st_r.rdata;
   assign o_loopback   = st_r.ctrl[`PBM_C_LOOP];
   assign o_speed      = pbm_speed_e'({st_r.ctrl[`PBM_C_SPD_HI],
                                       st_r.ctrl[`PBM_C_SPD_LO]});
   assign o_full_dup   = st_r.ctrl[`PBM_C_DUP];
   assign o_an_en      = st_r.ctrl[`PBM_C_ANEN];
   assign o_an_restart = st_r.an_rs;
   assign o_power_down = st_r.ctrl[`PBM_C_PDN];
   assign o_col_test   = st_r.ctrl[`PBM_C_COLT];
   assign o_soft_rst   = st_r.srst;

   // Isolate gates both directions at the MAC side
   assign o_mac_oe   = !iso;
   assign o_mac_rxd  = iso ? 8'h00 : i_med_rxd;
   assign o_mac_rxdv = !iso && i_med_rxdv;
   assign o_mac_txd  = iso ? 8'h00 : i_mac_txd;
   assign o_mac_txen = !iso && i_mac_txen;
endmodule

//--- pbm_station.sv
// Management station model; strobes move on the falling edge
module pbm_station (
   input  wire logic          i_clk,   // System clock
   output logic               o_wr,    // Write strobe
   output logic               o_rd,    // Read strobe
   output pbm_pkg::pbm_addr_t o_addr,  // Register address
   output pbm_pkg::pbm_word_t o_wdata, // Write data
   input  wire pbm_pkg::pbm_word_t i_rdata  // Read data
);
   import pbm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 5'h1F;
      o_wdata = 16'h5A5A;
   end
   task automatic wr(input pbm_addr_t a, input pbm_word_t d);
      @(negedge i_clk);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(negedge i_clk);
      o_wr = 1'b0;
      // Released data flips so a stale value is never mistaken for live
      o_wdata = ~d;
      if (a == 5'h00 && d[15]) repeat (2) @(negedge i_clk);
   endtask
   task automatic rd(input pbm_addr_t a, output pbm_word_t d);
      @(negedge i_clk);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_clk);
      o_rd = 1'b0;
      d = i_rdata;
   endtask
   task automatic rmw(input pbm_word_t m, input pbm_word_t v);
      pbm_word_t d;
      rd(5'h00, d);
      wr(5'h00, (d & ~m) | v);
   endtask
endmodule

//--- pbm_regs_sva.sv
`include "pbm_map.svh"
module pbm_regs_sva (
   input wire logic               i_clk,        // Clock
   input wire logic               i_sys_rst,    // Reset
   input wire logic               i_wr,         // Write
   input wire logic               i_rd,         // Read
   input wire pbm_pkg::pbm_addr_t i_addr,       // Address
   input wire pbm_pkg::pbm_word_t i_wdata,      // Write data
   input wire pbm_pkg::pbm_word_t o_rdata,      // Read data
   input wire logic [7:0]         o_mac_txd,    // Tx data
   input wire logic               o_mac_txen,   // Tx enable
   input wire logic [7:0]         o_mac_rxd,    // Rx data
   input wire logic               o_mac_rxdv,   // Rx valid
   input wire logic               o_mac_oe,     // Output enable
   input wire logic               o_loopback,   // Loopback
   input wire pbm_pkg::pbm_speed_e o_speed,     // Speed
   input wire logic               o_full_dup,   // Duplex
   input wire logic               o_an_restart, // Restart pulse
   input wire logic               o_col_test,   // Collision test
   input wire logic               o_soft_rst    // Soft reset pulse
);
   import pbm_pkg::*;
   // A write in the soft reset cycle is overwritten by defaults
   wire w0 = i_wr && i_addr == 5'h00 && !i_wdata[15] && !o_soft_rst;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_srst;
      i_wr && i_addr == 5'h00 && i_wdata[15] |=> o_soft_rst ##1 !o_soft_rst;
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset");
   property p_anrs;
      w0 && i_wdata[9] |=> o_an_restart ##1 !o_an_restart;
   endproperty
   a_anrs: assert property (p_anrs) else $error("an restart");
   property p_spd;
      w0 |=> o_speed == {$past(i_wdata[6]), $past(i_wdata[13])};
   endproperty
   a_spd: assert property (p_spd) else $error("speed");
   property p_loop;
      w0 |=> o_loopback == $past(i_wdata[14]) && o_full_dup == $past(i_wdata[8]);
   endproperty
   a_loop: assert property (p_loop) else $error("loop dup");
   property p_colt;
      w0 |=> o_col_test == $past(i_wdata[7]);
   endproperty
   a_colt: assert property (p_colt) else $error("col test");
   property p_oe;
      w0 |=> o_mac_oe == !$past(i_wdata[10]);
   endproperty
   a_oe: assert property (p_oe) else $error("isolate oe");
   property p_iso;
      !o_mac_oe |-> o_mac_txd == 8'h00 && !o_mac_txen && o_mac_rxd == 8'h00 && !o_mac_rxdv;
   endproperty
   a_iso: assert property (p_iso) else $error("isolate out");
   property p_stat;
      i_rd && i_addr == 5'h01 |=> (o_rdata & 16'hFF_C9) == `PBM_STAT_FIXED;
   endproperty
   a_stat: assert property (p_stat) else $error("status");
   property p_idh;
      i_rd && i_addr == 5'h02 |=> o_rdata == `PBM_OUI_HI;
   endproperty
   a_idh: assert property (p_idh) else $error("id high");
   property p_idl;
      i_rd && i_addr == 5'h03 |=> o_rdata == {`PBM_OUI_LO, `PBM_MODEL, `PBM_REV};
   endproperty
   a_idl: assert property (p_idl) else $error("id low");
endmodule
bind pbm_regs pbm_regs_sva i_sva (.i_clk, .i_sys_rst, .i_wr, .i_rd, .i_addr,
   .i_wdata, .o_rdata, .o_mac_txd, .o_mac_txen, .o_mac_rxd, .o_mac_rxdv,
   .o_mac_oe, .o_loopback, .o_speed, .o_full_dup, .o_an_restart,
   .o_col_test, .o_soft_rst);

//--- phy_base_mode_status_regs_tb.sv
`include "pbm_map.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module phy_base_mode_status_regs_tb;
   import pbm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, wr, rd, lnk, rf, jb, ad, txen, rxdv;
   logic [7:0] txd, rxd, otxd, orxd;
   logic otxen, orxdv, oe, lp, fd, an, anr, pd, ct, sr;
   pbm_addr_t addr;
   pbm_word_t wd, rdat, d;
   pbm_speed_e spd;
   int n_tests = 0;
   int n_mismatch = 0;
   int n_srst = 0;
   pbm_station i_sta (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
      .o_wdata(wd), .i_rdata(rdat));
   pbm_regs i_dut (.i_clk(clk), .i_sys_rst(rst), .i_wr(wr), .i_rd(rd),
      .i_addr(addr), .i_wdata(wd), .o_rdata(rdat), .i_link_up(lnk),
      .i_rem_fault(rf), .i_jabber(jb), .i_an_done(ad), .i_mac_txd(txd),
      .i_mac_txen(txen), .o_mac_txd(otxd), .o_mac_txen(otxen),
      .i_med_rxd(rxd), .i_med_rxdv(rxdv), .o_mac_rxd(orxd),
      .o_mac_rxdv(orxdv), .o_mac_oe(oe), .o_loopback(lp), .o_speed(spd),
      .o_full_dup(fd), .o_an_en(an), .o_an_restart(anr), .o_power_down(pd),
      .o_col_test(ct), .o_soft_rst(sr));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Soft reset pulse is one cycle wide; count it where it is settled
   always @(negedge clk) if (sr === 1'b1) n_srst++;
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic t_defaults;
      i_sta.rd(5'h00, d);
      `CHK("ctrl", 16'h10_40, d)
      `CHK("an_en", 1'b1, an)
      `CHK("pdn", 1'b0, pd)
      `CHK("speed", PBM_SPD_1000, spd)
      i_sta.rd(5'h02, d);
      `CHK("idh", `PBM_OUI_HI, d)
      i_sta.rd(5'h03, d);
      `CHK("idl", {`PBM_OUI_LO, `PBM_MODEL, `PBM_REV}, d)
      i_sta.wr(5'h01, 16'hFF_FF);
      i_sta.rd(5'h01, d);
      `CHK("stat", 16'h79_C9, d)
      i_sta.rd(5'h07, d);
      `CHK("unmapped", 16'h00_00, d)
   endtask
   task automatic t_speed;
      for (int i = 0; i < 4; i++) begin
         i_sta.rmw(16'h61_40, {1'b0, 1'b1, i[0], 4'h0, i[0], 1'b0, i[1], 6'h0});
         `CHK("speed", i[1:0], spd)
         `CHK("loop", 1'b1, lp)
         `CHK("dup", i[0], fd)
      end
      i_sta.rmw(16'h40_00, 16'h00_00);
   endtask
   task automatic t_iso;
      `CHK("txd", 8'hA5, otxd)
      i_sta.rmw(16'h04_00, 16'h04_00);
      `CHK("oe", 1'b0, oe)
      `CHK("mac", 18'h0, {otxd, otxen, orxd, orxdv})
      i_sta.rmw(16'h04_00, 16'h00_00);
      `CHK("rxd", 9'h179, {orxd, orxdv})
   endtask
   task automatic t_selfclr;
      i_sta.rmw(16'h02_80, 16'h02_80);
      `CHK("anr", 1'b1, anr)
      `CHK("colt", 1'b1, ct)
      i_sta.rd(5'h00, d);
      `CHK("bit9", 1'b0, d[9])
      i_sta.rmw(16'h01_80, 16'h01_00);
      `CHK("colt", 1'b0, ct)
      // Station powers the port down, as after a forced-mode link loss
      i_sta.rmw(16'h08_00, 16'h08_00);
      `CHK("pdn", 1'b1, pd)
      i_sta.wr(5'h00, 16'h81_00);
      `CHK("srst", 1, n_srst)
      `CHK("pdn", 1'b0, pd)
      i_sta.rd(5'h00, d);
      `CHK("ctrl", 16'h10_40, d)
   endtask
   task automatic t_latch;
      ad = 1'b1;
      lnk = 1'b1;
      repeat (4) @(negedge clk);
      i_sta.rd(5'h01, d);
      i_sta.rd(5'h01, d);
      `CHK("link", 2'b11, {d[5], d[2]})
      lnk = 1'b0;
      repeat (4) @(negedge clk);
      lnk = 1'b1;
      rf = 1'b1;
      jb = 1'b1;
      repeat (4) @(negedge clk);
      rf = 1'b0;
      jb = 1'b0;
      repeat (4) @(negedge clk);
      i_sta.rd(5'h01, d);
      `CHK("latched", 3'b101, {d[4], d[2], d[1]})
      i_sta.rd(5'h01, d);
      `CHK("live", 3'b010, {d[4], d[2], d[1]})
      i_sta.rmw(16'h10_00, 16'h00_00);
      `CHK("an_en", 1'b0, an)
      i_sta.rd(5'h01, d);
      `CHK("andone", 1'b0, d[5])
   endtask
   initial begin
      {rst, lnk, rf, jb, ad} = 5'h10;
      {txd, txen, rxd, rxdv} = {8'hA5, 1'b1, 8'hBC, 1'b1};
      repeat (16) @(negedge clk);
      rst = 1'b0;
      t_defaults();
      t_speed();
      t_iso();
      t_selfclr();
      t_latch();
      tally_and_finish();
   end
   // Guards against a hung task; expiry is counted as a failure
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
